// [mms_top.sv]
`include "mms_map.svh"
module mms_top #(
  parameter logic [16:0] TICK_CYCLES = 17'(`MMS_TICK_CYCLES)
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [2:0]  mode_sel_i,
  input  wire logic        four_sensor_variant_i,
  input  wire logic        tc2_on_four_i,
  input  wire logic        txrx_system_i,
  input  wire logic        muting_sensor_first_i,
  input  wire logic        muting_sensor_second_i,
  input  wire logic        muting_sensor_third_i,
  input  wire logic        muting_sensor_fourth_i,
  input  wire logic        alt_second_i,
  input  wire logic        muting_gate_timeout_input_i,
  input  wire logic        field_broken_i,
  input  wire logic        top_beam_broken_i,
  input  wire logic        restart_button_i,
  input  wire logic        contactor_check_sel_i,
  input  wire logic        contactor_feedback_check_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             safety_switch_output_o,
  output logic             muting_active_o,
  output logic             restart_interlock_o,
  output logic             contactor_check_en_o,
  output logic      [2:0]  mode_o,
  output logic             mode_valid_o,
  output logic             irq_o
);
  mms_pkg::mms_regs_s  r;
  mms_pkg::mms_regs_s  n;
  mms_pkg::mms_type_e  typ;
  logic [16:0]         pins;
  logic                tick;
  logic [2:0]          m;
  logic                long_to;
  logic                ext_ok;
  logic                alt_ok;
  logic                gate_ok;
  logic                partial;
  logic                ccheck_ok;
  logic [12:0]         filt;
  logic [28:0]         limit;
  logic                sa;
  logic                sb;
  logic                gin;
  logic                field;
  logic                top;
  logic                trip;
  logic                start_ok;
  logic [5:0]          ev;
  logic [31:0]         status;
  logic                irq_stat_timeout;

  // Counter saturating at its top value
  function automatic logic [28:0] inc_ms(input logic [28:0] c);
    inc_ms = (c == 29'h1FFFFFFF) ? c : c + 29'h00000001;
  endfunction

  // Short counter saturating at its top value
  function automatic logic [12:0] inc_sh(input logic [12:0] c);
    inc_sh = (c == 13'h1FFF) ? c : c + 13'h0001;
  endfunction

  // ==========================================================
  // Pin synchroniser and tick
  mms_sync #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .async_i ({contactor_feedback_check_i, contactor_check_sel_i,
               restart_button_i, top_beam_broken_i, field_broken_i,
               muting_gate_timeout_input_i, alt_second_i,
               muting_sensor_fourth_i, muting_sensor_third_i,
               muting_sensor_second_i, muting_sensor_first_i,
               txrx_system_i, tc2_on_four_i, four_sensor_variant_i,
               mode_sel_i}),
    .sync_o  (pins),
    .tick_o  (tick)
  );

  // ==========================================================
  // Feature decode from the latched mode
  always_comb
  begin
    m = r.mode;
    if (m == 3'h3 || m == 3'h4)
      typ = mms_pkg::MMS_SC2;
    else if (r.var4 && !r.tc2f)
      typ = mms_pkg::MMS_TC4;
    else
      typ = mms_pkg::MMS_TC2;
    long_to = (m == 3'h2 || m == 3'h4);
    ext_ok = (m == 3'h1 || m == 3'h5 || m == 3'h6);
    alt_ok = (m == 3'h2 || m == 3'h3 || m == 3'h4 ||
              (m == 3'h6 && !r.var4));
    gate_ok = (m == 3'h5);
    partial = (m == 3'h6) && r.txrx;
    ccheck_ok = r.edmsel && (m == 3'h1 || m == 3'h2 ||
             m == 3'h3 || m == 3'h5);
    if (typ == mms_pkg::MMS_TC4)
      filt = 13'h0000;
    else if (r.var4)
      filt = 13'(`MMS_FILT_SHORT_MS);
    else
      filt = 13'(`MMS_FILT_MS);
    if (long_to && r.ext != mms_pkg::MMS_EXT_DONE)
      limit = 29'(`MMS_TO_LONG_MS);
    else
      limit = 29'(`MMS_TO_STD_MS);
  end

  // Sensor pairing and protective field view
  always_comb
  begin
    sa = pins[`MMS_PIN_S1];
    sb = pins[`MMS_PIN_S2] | (alt_ok & pins[`MMS_PIN_ALT]);
    if (typ == mms_pkg::MMS_TC4)
    begin
      sa = pins[`MMS_PIN_S1] | pins[`MMS_PIN_S4];
      sb = pins[`MMS_PIN_S2] | pins[`MMS_PIN_S3] |
           (alt_ok & pins[`MMS_PIN_ALT]);
    end
    gin = pins[`MMS_PIN_GIN];
    field = pins[`MMS_PIN_FIELD];
    top = pins[`MMS_PIN_TOP];
    trip = (field || top) && !(r.st == mms_pkg::MMS_MUTE &&
           !(partial && top));
    start_ok = r.allow && r.mode_ok && !r.locked &&
               (!gate_ok || gin);
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    n = r;
    ev = 6'h00;
    n.btn_q = pins[`MMS_PIN_BTN];
    // Mode and straps caught once after the synchroniser settles
    if (!r.latched)
    begin
      n.settle = r.settle + 2'h1;
      if (r.settle == 2'h3)
      begin
        n.latched = 1'b1;
        n.mode = pins[`MMS_PIN_MODE +: 3];
        n.var4 = pins[`MMS_PIN_VAR4];
        n.tc2f = pins[`MMS_PIN_TC2F];
        n.txrx = pins[`MMS_PIN_TXRX];
        n.edmsel = pins[`MMS_PIN_EDMSEL];
        n.mode_ok = (pins[`MMS_PIN_MODE +: 3] != 3'h0) &&
                    (pins[`MMS_PIN_MODE +: 3] != 3'h7);
        ev[`MMS_EV_BADMODE] = !n.mode_ok;
      end
    end
    // Muting sequence
    unique case (r.st)
      mms_pkg::MMS_IDLE:
      begin
        n.win_ms = 13'h0000;
        if (typ == mms_pkg::MMS_SC2)
        begin
          if (sa && !sb)
            n.st = mms_pkg::MMS_ARM;
        end
        else if (sa || sb)
          n.st = mms_pkg::MMS_ARM;
      end
      mms_pkg::MMS_ARM:
      begin
        if (tick)
          n.win_ms = inc_sh(r.win_ms);
        if (sa && sb && start_ok)
        begin
          n.st = mms_pkg::MMS_MUTE;
          n.to_ms = 29'h00000000;
          n.tot_ms = 29'h00000000;
          n.drop_ms = 13'h0000;
          n.ext = (ext_ok && gin) ? mms_pkg::MMS_EXT_ARMED :
                  mms_pkg::MMS_EXT_OFF;
          ev[`MMS_EV_START] = 1'b1;
        end
        else if (!sa && (typ == mms_pkg::MMS_SC2 || !sb))
          n.st = mms_pkg::MMS_IDLE;
        else if (typ != mms_pkg::MMS_SC2 &&
                 r.win_ms >= 13'(`MMS_SIMUL_MS))
        begin
          n.st = mms_pkg::MMS_HOLD;
          ev[`MMS_EV_SEQERR] = 1'b1;
        end
      end
      mms_pkg::MMS_MUTE:
      begin
        // Timeout bookkeeping and extension
        if (tick)
        begin
          n.tot_ms = inc_ms(r.tot_ms);
          if (r.ext != mms_pkg::MMS_EXT_RUN)
            n.to_ms = inc_ms(r.to_ms);
        end
        if (r.ext == mms_pkg::MMS_EXT_ARMED && !gin)
        begin
          n.ext = mms_pkg::MMS_EXT_RUN;
          n.to_ms = 29'h00000000;
        end
        if (r.ext == mms_pkg::MMS_EXT_RUN && (gin ||
            r.tot_ms >= 29'(`MMS_TO_LONG_MS)))
        begin
          n.ext = mms_pkg::MMS_EXT_DONE;
          n.to_ms = 29'h00000000;
        end
        // Single sensor dropout filter
        if (sa ^ sb)
        begin
          if (tick)
            n.drop_ms = inc_sh(r.drop_ms);
        end
        else
          n.drop_ms = 13'h0000;
        if (!sa && !sb)
        begin
          n.st = mms_pkg::MMS_IDLE;
          ev[`MMS_EV_END] = 1'b1;
        end
        else if (r.ext != mms_pkg::MMS_EXT_RUN &&
                 r.to_ms >= limit)
        begin
          n.st = mms_pkg::MMS_HOLD;
          ev[`MMS_EV_TIMEOUT] = 1'b1;
        end
        else if ((sa ^ sb) && typ != mms_pkg::MMS_SC2 &&
                 r.drop_ms >= filt)
        begin
          n.st = mms_pkg::MMS_HOLD;
          ev[`MMS_EV_SEQERR] = 1'b1;
        end
        else if (!r.allow)
          n.st = mms_pkg::MMS_HOLD;
      end
      mms_pkg::MMS_HOLD:
      begin
        if (!sa && !sb)
          n.st = mms_pkg::MMS_IDLE;
      end
      default:
      begin
        n.st = mms_pkg::MMS_HOLD;
      end
    endcase
    // Restart interlock and safety switch output
    if (trip)
      n.locked = 1'b1;
    else if (r.locked && pins[`MMS_PIN_BTN] && !r.btn_q &&
             r.mode_ok && (!ccheck_ok || pins[`MMS_PIN_FB]))
      n.locked = 1'b0;
    ev[`MMS_EV_TRIP] = trip && !r.locked;
    n.ssd_on = !n.locked && !trip && r.mode_ok;
    // Register bus, set wins over clear
    n.irq_stat = r.irq_stat | ev;
    if (wr_i && addr_i == `MMS_ADDR_IRQ_STAT)
      n.irq_stat = (r.irq_stat & ~wdata_i[5:0]) | ev;
    if (wr_i && addr_i == `MMS_ADDR_CTRL)
      n.allow = wdata_i[`MMS_CTRL_ALLOW];
    if (wr_i && addr_i == `MMS_ADDR_IRQ_MASK)
      n.irq_mask = wdata_i[5:0];
    n.rdata = 32'h00000000;
    if (rd_i)
    begin
      unique case (addr_i)
        `MMS_ADDR_CTRL:     n.rdata = {31'h0, r.allow};
        `MMS_ADDR_STATUS:   n.rdata = status;
        `MMS_ADDR_IRQ_STAT: n.rdata = {26'h0, r.irq_stat};
        `MMS_ADDR_IRQ_MASK: n.rdata = {26'h0, r.irq_mask};
        default:            n.rdata = 32'h00000000;
      endcase
    end
  end

  // Status word
  assign status = {14'h0, ccheck_ok, r.ext, r.st, typ, r.locked,
                   r.ssd_on, r.mode_ok, r.mode};

  // ==========================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r <= '0;
      r.st <= mms_pkg::MMS_IDLE;
      r.ext <= mms_pkg::MMS_EXT_OFF;
      r.locked <= 1'b1;
      r.allow <= `MMS_CTRL_RST;
      r.irq_mask <= `MMS_MASK_RST;
    end
    else if (ce_i)
      r <= n;
  end

  // Outputs
  assign rdata_o = r.rdata;
  assign safety_switch_output_o = r.ssd_on;
  assign muting_active_o = (r.st == mms_pkg::MMS_MUTE);
  assign restart_interlock_o = r.locked;
  assign contactor_check_en_o = ccheck_ok;
  assign mode_o = r.mode;
  assign mode_valid_o = r.mode_ok;
  assign irq_o = |(r.irq_stat & r.irq_mask);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  partial_top_a: assert property (
    ce_i && r.st == mms_pkg::MMS_MUTE && partial && top
    |=> !r.ssd_on && r.locked)
    else $error("top beam muted in partial mode");
  mode_hold_a: assert property (
    r.latched |=> r.latched && $stable(r.mode) && $stable(r.var4))
    else $error("latched mode changed");
  seq_type_a: assert property (
    r.st == mms_pkg::MMS_MUTE && !r.var4 |->
    (typ == mms_pkg::MMS_SC2) == (m == 3'h3 || m == 3'h4))
    else $error("wrong muting type");
  timeout_a: assert property (
    ce_i && r.st == mms_pkg::MMS_MUTE && (sa || sb) &&
    r.ext != mms_pkg::MMS_EXT_RUN && r.to_ms >= limit
    |=> r.st == mms_pkg::MMS_HOLD && irq_stat_timeout)
    else $error("muting outlived timeout");
  ext_ignored_a: assert property (
    r.st == mms_pkg::MMS_MUTE && !ext_ok |->
    r.ext == mms_pkg::MMS_EXT_OFF)
    else $error("extension outside modes 1 5 6");
  ext_armed_a: assert property (
    ce_i && r.st == mms_pkg::MMS_ARM && n.st == mms_pkg::MMS_MUTE
    |=> (r.ext == mms_pkg::MMS_EXT_ARMED) == $past(ext_ok && gin))
    else $error("extension armed wrongly");
  gate_block_a: assert property (
    ce_i && r.st == mms_pkg::MMS_ARM && gate_ok && !gin
    |=> r.st != mms_pkg::MMS_MUTE)
    else $error("muting started with gate low");
  trip_lock_a: assert property (
    ce_i && trip |=> r.locked && !r.ssd_on ##1 !r.ssd_on)
    else $error("interlock missed a trip");
  ccheck_mode_a: assert property (
    contactor_check_en_o |-> m != 3'h4 && m != 3'h6)
    else $error("contactor check in mode 4 or 6");
  window_a: assert property (
    r.st == mms_pkg::MMS_ARM && typ != mms_pkg::MMS_SC2 |->
    r.win_ms <= 13'(`MMS_SIMUL_MS))
    else $error("simultaneity window overrun");
  filter_a: assert property (
    r.st == mms_pkg::MMS_MUTE && r.var4 &&
    typ == mms_pkg::MMS_TC2 |-> r.drop_ms <= 13'(`MMS_FILT_SHORT_MS))
    else $error("short dropout filter overrun");

  // Helper for the timeout check
  assign irq_stat_timeout = r.irq_stat[`MMS_EV_TIMEOUT];
endmodule

// [mms_map.svh]
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH
// ==========================================================
// Clock and millisecond tick
`define MMS_CLK_MHZ        125
`define MMS_TICK_US        1000
`define MMS_TICK_CYCLES    (`MMS_TICK_US * `MMS_CLK_MHZ)
// ==========================================================
// Muting times in their own units, and counts in ticks
`define MMS_TO_STD_MIN     10
`define MMS_TO_STD_MS      (`MMS_TO_STD_MIN * 60 * 1000)
`define MMS_TO_LONG_H      100
`define MMS_TO_LONG_MS     (`MMS_TO_LONG_H * 3600 * 1000)
`define MMS_SIMUL_S        4
`define MMS_SIMUL_MS       (`MMS_SIMUL_S * 1000)
`define MMS_FILT_S         3
`define MMS_FILT_MS        (`MMS_FILT_S * 1000)
`define MMS_FILT_SHORT_MS  100
`define MMS_MS_W           29
`define MMS_SH_W           13
// ==========================================================
// Synchronised pin vector layout
`define MMS_PIN_W          17
`define MMS_PIN_MODE       0
`define MMS_PIN_VAR4       3
`define MMS_PIN_TC2F       4
`define MMS_PIN_TXRX       5
`define MMS_PIN_S1         6
`define MMS_PIN_S2         7
`define MMS_PIN_S3         8
`define MMS_PIN_S4         9
`define MMS_PIN_ALT        10
`define MMS_PIN_GIN        11
`define MMS_PIN_FIELD      12
`define MMS_PIN_TOP        13
`define MMS_PIN_BTN        14
`define MMS_PIN_EDMSEL     15
`define MMS_PIN_FB         16
// ==========================================================
// Register offsets, fields and reset values
`define MMS_ADDR_CTRL      4'h0
`define MMS_ADDR_STATUS    4'h4
`define MMS_ADDR_IRQ_STAT  4'h8
`define MMS_ADDR_IRQ_MASK  4'hC
`define MMS_CTRL_ALLOW     0
`define MMS_CTRL_RST       1'h1
`define MMS_MASK_RST       6'h00
`define MMS_EV_W           6
`define MMS_EV_START       0
`define MMS_EV_END         1
`define MMS_EV_TIMEOUT     2
`define MMS_EV_SEQERR      3
`define MMS_EV_TRIP        4
`define MMS_EV_BADMODE     5
`endif

// [mms_pkg.sv]
package mms_pkg;
  typedef enum logic [2:0] {
    MMS_TC2 = 3'h1,
    MMS_SC2 = 3'h2,
    MMS_TC4 = 3'h4
  } mms_type_e;
  typedef enum logic [3:0] {
    MMS_IDLE = 4'h1,
    MMS_ARM  = 4'h2,
    MMS_MUTE = 4'h4,
    MMS_HOLD = 4'h8
  } mms_state_e;
  typedef enum logic [3:0] {
    MMS_EXT_OFF   = 4'h1,
    MMS_EXT_ARMED = 4'h2,
    MMS_EXT_RUN   = 4'h4,
    MMS_EXT_DONE  = 4'h8
  } mms_ext_e;
  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] tick_cnt;
    logic        tick;
  } mms_sync_s;
  typedef struct packed {
    logic [2:0]  mode;
    logic [1:0]  settle;
    logic        latched;
    logic        var4;
    logic        tc2f;
    logic        txrx;
    logic        edmsel;
    logic        mode_ok;
    mms_state_e  st;
    mms_ext_e    ext;
    logic [12:0] win_ms;
    logic [12:0] drop_ms;
    logic [28:0] to_ms;
    logic [28:0] tot_ms;
    logic        btn_q;
    logic        locked;
    logic        ssd_on;
    logic        allow;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic [31:0] rdata;
  } mms_regs_s;
endpackage

// [mms_sync.sv]
`include "mms_map.svh"
module mms_sync #(
  parameter logic [16:0] TICK_CYCLES = 17'(`MMS_TICK_CYCLES)
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [16:0] async_i,
  output logic      [16:0] sync_o,
  output logic             tick_o
);
  mms_pkg::mms_sync_s r;
  mms_pkg::mms_sync_s n;

  // ==========================================================
  // Two-stage synchroniser and millisecond tick
  always_comb
  begin
    n = r;
    n.s1 = async_i;
    n.s2 = r.s1;
    n.tick = 1'b0;
    if (r.tick_cnt >= TICK_CYCLES - 17'h00001)
    begin
      n.tick_cnt = 17'h00000;
      n.tick = 1'b1;
    end
    else
    begin
      n.tick_cnt = r.tick_cnt + 17'h00001;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      r <= '0;
    else if (ce_i)
      r <= n;
  end

  assign sync_o = r.s2;
  assign tick_o = r.tick & ce_i;
endmodule

// [mms_far_model.sv]
module mms_far_model (
  input  wire logic clk_i,
  input  wire logic ssd_i,
  output logic      sensor_first_o,
  output logic      sensor_second_o,
  output logic      sensor_third_o,
  output logic      sensor_fourth_o,
  output logic      alt_second_o,
  output logic      gate_o,
  output logic      field_o,
  output logic      top_o,
  output logic      button_o,
  output logic      feedback_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Idle levels: sensors free, field clear, gate input high
  initial
  begin
    sensor_first_o = 1'h0;
    sensor_second_o = 1'h0;
    sensor_third_o = 1'h0;
    sensor_fourth_o = 1'h0;
    alt_second_o = 1'h0;
    gate_o = 1'h1;
    field_o = 1'h0;
    top_o = 1'h0;
    button_o = 1'h0;
  end
  // Contactors drop out one cycle after the safety output goes off
  always @(posedge clk_i)
    feedback_o <= ~ssd_i;
  // ==========================================================
  // Operator presses the restart button for three cycles
  task automatic press();
    @(posedge clk_i);
    button_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    button_o <= 1'h0;
  endtask
  // First sensor group; fourth joins it on a four-sensor pass
  task automatic set_a(input logic v, input logic four);
    @(posedge clk_i);
    sensor_first_o <= v;
    if (four)
      sensor_fourth_o <= v;
  endtask
  // Second group, or the control's signal on the alternate pin
  task automatic set_b(input logic v, input logic four, input logic alt);
    @(posedge clk_i);
    if (alt)
      alt_second_o <= v;
    else
    begin
      sensor_second_o <= v;
      if (four)
        sensor_third_o <= v;
    end
  endtask
  // Beam state and gate level; gate is set before muting starts
  task automatic set_env(input logic f, input logic t, input logic g);
    @(posedge clk_i);
    field_o <= f;
    top_o <= t;
    gate_o <= g;
  endtask
endmodule

// [tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int m, v4, t2, tx, gate, alt, top, mute;} mms_case_s;
  logic        clk_i;
  logic        rstn_i = 1'h0;
  logic [2:0]  mode_sel_i = 3'h1;
  logic        var4 = 1'h0;
  logic        tc2f = 1'h0;
  logic        txrx = 1'h0;
  logic        ccheck_sel = 1'h0;
  logic        ce = 1'h1;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'h0;
  logic        rd_i = 1'h0;
  logic        s1, s2, s3, s4, alt, gate, field, top, btn, fb;
  logic [31:0] rdata_o;
  logic        ssd, mute, locked, cce, valid, irq;
  logic [2:0]  mode_o;
  logic [31:0] d;
  int          fail_count = 0;
  int          compares = 0;
  integer      seed = 32'h48FB1CCC;
  mms_case_s   tbl [11] = '{'{1,0,0,0,1,0,0,1}, '{3,0,0,0,1,0,0,1},
    '{2,0,0,0,1,1,0,1}, '{1,0,0,0,1,1,0,0}, '{5,0,0,0,0,0,0,0},
    '{5,0,0,0,1,0,0,1}, '{6,0,0,1,1,0,1,1}, '{1,0,0,1,1,0,1,1},
    '{1,1,0,0,1,0,0,1}, '{2,1,1,0,1,0,0,1}, '{6,1,0,0,1,1,0,0}};
  // ==========================================================
  // Design, far side and clock
  mms_top #(.TICK_CYCLES(17'h00004)) mms_top_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .ce_i(ce), .mode_sel_i(mode_sel_i),
    .four_sensor_variant_i(var4), .tc2_on_four_i(tc2f),
    .txrx_system_i(txrx), .muting_sensor_first_i(s1),
    .muting_sensor_second_i(s2), .muting_sensor_third_i(s3),
    .muting_sensor_fourth_i(s4), .alt_second_i(alt),
    .muting_gate_timeout_input_i(gate), .field_broken_i(field),
    .top_beam_broken_i(top), .restart_button_i(btn),
    .contactor_check_sel_i(ccheck_sel), .contactor_feedback_check_i(fb),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .safety_switch_output_o(ssd),
    .muting_active_o(mute), .restart_interlock_o(locked),
    .contactor_check_en_o(cce), .mode_o(mode_o), .mode_valid_o(valid),
    .irq_o(irq));
  mms_far_model mms_far_model_i (.clk_i(clk_i), .ssd_i(ssd),
    .sensor_first_o(s1), .sensor_second_o(s2), .sensor_third_o(s3),
    .sensor_fourth_o(s4), .alt_second_o(alt), .gate_o(gate),
    .field_o(field), .top_o(top), .button_o(btn), .feedback_o(fb));
  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  // ==========================================================
  // Reference model of the mode table
  function automatic int exp_type(int m, int v4, int t2);
    if (m == 3 || m == 4)
      return 2;
    return (v4 != 0 && t2 == 0) ? 4 : 1;
  endfunction
  function automatic int exp_cce(int m, int sel);
    return (sel != 0 && (m == 1 || m == 2 || m == 3 || m == 5)) ? 1 : 0;
  endfunction
  // ==========================================================
  // Comparison, bus cycles, reset and verdict
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
      fail_count++;
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 v = rdata_o;
  endtask
  task automatic boot(input int m, v4, t2, tx, sel, hold);
    @(posedge clk_i);
    rstn_i <= 1'h0;
    mode_sel_i <= 3'(m);
    var4 <= 1'(v4);
    tc2f <= 1'(t2);
    txrx <= 1'(tx);
    ccheck_sel <= 1'(sel);
    repeat (hold) @(posedge clk_i);
    rstn_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One pass of an object through the muting sensors
  task automatic run(input mms_case_s c);
    logic four;
    int   oexp;
    four = (c.v4 != 0 && c.t2 == 0);
    oexp = (c.mute != 0 && !(c.top != 0 && c.tx != 0 && c.m == 6));
    boot(c.m, c.v4, c.t2, c.tx, 1, 2);
    mms_far_model_i.set_env(1'h0, 1'h0, 1'(c.gate));
    mms_far_model_i.press();
    wait_c(6);
    chk("output on", 32'h1, 32'(ssd));
    bus_wr(4'hC, 32'h3F);
    mms_far_model_i.set_a(1'h1, four);
    wait_c(4 * ($unsigned($random(seed)) % 200 + 1));
    mms_far_model_i.set_b(1'h1, four, 1'(c.alt));
    @(posedge clk_i);
    mode_sel_i <= 3'h0;
    wait_c(6);
    chk("muting", 32'(c.mute), 32'(mute));
    chk("mode held", 32'(c.m), 32'(mode_o));
    mms_far_model_i.set_env(1'h1, 1'(c.top), 1'(c.gate));
    wait_c(6);
    chk("output", 32'(oexp), 32'(ssd));
    mms_far_model_i.set_a(1'h0, four);
    mms_far_model_i.set_b(1'h0, four, 1'(c.alt));
    mms_far_model_i.set_env(1'h0, 1'h0, 1'(c.gate));
    wait_c(6);
    chk("muting end", 32'h0, 32'(mute));
    bus_rd(4'h8, d);
    chk("start event", 32'(c.mute), 32'(d[0]));
    chk("irq level", 32'(d != 32'h0), 32'(irq));
    bus_wr(4'h8, 32'h3F);
    bus_rd(4'h8, d);
    chk("events cleared", 32'h0, d);
    chk("irq low", 32'h0, 32'(irq));
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    boot(1, 0, 0, 0, 1, 20);
    bus_rd(4'h0, d);
    chk("ctrl reset", 32'h1, d);
    bus_rd(4'hC, d);
    chk("mask reset", 32'h0, d);
    bus_rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    // A write while the clock enable is low must be ignored
    @(posedge clk_i);
    ce <= 1'h0;
    bus_wr(4'h0, 32'h0);
    @(posedge clk_i);
    ce <= 1'h1;
    bus_rd(4'h0, d);
    chk("frozen write", 32'h1, d);
    bus_wr(4'h0, 32'h0);
    bus_rd(4'h0, d);
    chk("ctrl write", 32'h0, d);
    for (int v = 0; v < 2; v++)
      for (int m = 0; m < 8; m++)
      begin
        int sel;
        int t2;
        int ok;
        sel = $unsigned($random(seed)) % 2;
        t2 = $unsigned($random(seed)) % 2;
        ok = (m >= 1 && m <= 6);
        boot(m, v, t2, 0, sel, 2);
        bus_rd(4'h4, d);
        chk("mode", 32'(m), 32'(mode_o));
        chk("mode valid", 32'(ok), 32'(valid));
        chk("status mode", 32'(m), 32'(d[2:0]));
        chk("locked", 32'h1, 32'(locked));
        if (ok != 0)
        begin
          chk("type", 32'(exp_type(m, v, t2)), 32'(d[8:6]));
          chk("contactor", 32'(exp_cce(m, sel)), 32'(cce));
          chk("status contactor", 32'(exp_cce(m, sel)), 32'(d[17]));
        end
      end
    foreach (tbl[i])
      run(tbl[i]);
    boot(1, 0, 0, 0, 1, 2);
    mms_far_model_i.press();
    bus_wr(4'h8, 32'h3F);
    mms_far_model_i.set_a(1'h1, 1'h0);
    wait_c(4 * 4010);
    mms_far_model_i.set_b(1'h1, 1'h0, 1'h0);
    wait_c(6);
    chk("late second", 32'h0, 32'(mute));
    bus_rd(4'h8, d);
    chk("sequence error", 32'h1, 32'(d[3]));
    close_out();
  end
  // Cuts a hang short well after the expected run length
  initial
  begin
    #600000;
    fail_count++;
    close_out();
  end
endmodule
